// ---- src/efpb_pkg.sv ----
/*
 * Package for the residual overcurrent stage pick-up block: register map,
 * setting codes, field layouts and carrier structs.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz clock.
 */
package efpb_pkg;

    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CYCLE_US      = 1000;
    localparam int unsigned CYCLE_CLKS    = (CLK_HZ / 1_000_000) * CYCLE_US;
    localparam int unsigned TS_MS         = 1;
    localparam int unsigned TS_CLKS       = (CLK_HZ / 1000) * TS_MS;

    localparam int unsigned MAG_W         = 16;
    localparam int unsigned RATIO_W       = 16;

    // Release ratio in percent of the pick-up level
    localparam logic [7:0]  RESET_PCT     = 8'h61;
    localparam logic [7:0]  FULL_PCT      = 8'h64;

    // Register byte addresses
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_PICKUP    = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_RATIO     = 8'h0C;
    localparam logic [7:0]  REG_ANGLE     = 8'h10;
    localparam logic [7:0]  REG_OPTIME    = 8'h14;
    localparam logic [7:0]  REG_REMAIN    = 8'h18;
    localparam logic [7:0]  REG_EVENT     = 8'h1C;
    localparam logic [7:0]  REG_TSTAMP    = 8'h20;

    // Control field positions
    localparam int unsigned CTL_REMOTE    = 0;
    localparam int unsigned CTL_FORCE     = 2;
    localparam int unsigned CTL_MAG       = 4;
    localparam int unsigned CTL_INSEL     = 6;
    localparam int unsigned CTL_INRUSH    = 8;
    localparam int unsigned CTL_SWBLK     = 9;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0051;
    localparam logic [15:0] PICKUP_RESET  = 16'h04B0;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        REMOTE_RSVD, REMOTE_DISABLED, REMOTE_ALLOWED, REMOTE_RSVD3
    } efpb_remote_e;

    typedef enum logic [1:0] {
        ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED
    } efpb_status_e;

    typedef enum logic [1:0] {
        MAG_RSVD, MAG_RMS, MAG_TRMS, MAG_P2P
    } efpb_mag_e;

    typedef enum logic [1:0] {
        IN_RSVD, IN_COARSE, IN_SENSITIVE, IN_CALC
    } efpb_insel_e;

    typedef struct packed {
        logic [15:0] rms;
        logic [15:0] trms;
        logic [15:0] p2p;
    } efpb_chan_s;

    typedef struct packed {
        logic        start_on;
        logic        start_off;
        logic        trip_on;
        logic        trip_off;
        logic        block_on;
        logic        block_off;
    } efpb_events_s;

endpackage

// ---- src/efpb_stage.sv ----
/*
 * Residual overcurrent stage: channel and magnitude selection, threshold
 * comparison with fixed release ratio, blocking, forced status, read-only
 * indications and time-stamped on/off events, with an AXI4-Lite slave.
 * Assumes pre-processed magnitudes and an external operate timer that
 * supplies trip, expected time and remaining time.
 */
`timescale 1ns/1ps
module efpb_stage #(
    parameter int unsigned CYCLE_CLKS = efpb_pkg::CYCLE_CLKS,
    parameter int unsigned TS_CLKS    = efpb_pkg::TS_CLKS
) (
    input  wire logic                 aclk,              // 100 MHz clock
    input  wire logic                 aresetn,           // Synchronous reset, active low
    input  wire logic [7:0]           s_axi_awaddr,      // Write address
    input  wire logic                 s_axi_awvalid,     // Write address valid
    output logic                      s_axi_awready,     // Write address ready
    input  wire logic [31:0]          s_axi_wdata,       // Write data
    input  wire logic [3:0]           s_axi_wstrb,       // Write strobes
    input  wire logic                 s_axi_wvalid,      // Write data valid
    output logic                      s_axi_wready,      // Write data ready
    output logic [1:0]                s_axi_bresp,       // Write response
    output logic                      s_axi_bvalid,      // Write response valid
    input  wire logic                 s_axi_bready,      // Write response ready
    input  wire logic [7:0]           s_axi_araddr,      // Read address
    input  wire logic                 s_axi_arvalid,     // Read address valid
    output logic                      s_axi_arready,     // Read address ready
    output logic [31:0]               s_axi_rdata,       // Read data
    output logic [1:0]                s_axi_rresp,       // Read response
    output logic                      s_axi_rvalid,      // Read data valid
    input  wire logic                 s_axi_rready,      // Read data ready
    input  wire efpb_pkg::efpb_chan_s coarse_residual_channel,     // First measured channel
    input  wire efpb_pkg::efpb_chan_s sensitive_residual_channel,  // Second measured channel
    input  wire logic [15:0]          calculated_residual_channel, // Calculated RMS
    input  wire logic                 block_in,          // Blocking matrix input
    input  wire logic                 inrush_detect,     // Second harmonic over limit
    input  wire logic                 forcing_enable,    // Global stage forcing / test mode
    input  wire logic                 scada_write,       // Pick-up write from SCADA
    input  wire logic [15:0]          scada_level,       // SCADA pick-up value
    input  wire logic                 voltages_present,  // Phase voltages available
    input  wire logic [15:0]          angle_vs_voltage,  // Angle vs U1, 0.01 deg
    input  wire logic [15:0]          angle_vs_current,  // Angle vs I1, 0.01 deg
    input  wire logic [2:0]           fault_type_in,     // Detected fault type 0..6
    input  wire logic                 trip_in,           // Operate timer expired
    input  wire logic [31:0]          expected_time,     // Expected operate time, 5 ms units
    input  wire logic [31:0]          remaining_time,    // Time left to trip, 5 ms units
    output logic                      start_out,         // Start output
    output logic                      trip_out,          // Trip output
    output logic                      blocked_out,       // Blocked output
    output efpb_pkg::efpb_events_s    events,            // One-cycle event pulses
    output logic [31:0]               event_stamp,       // Stamp of last events, ms
    output logic [15:0]               event_current,     // Current at last event
    output logic                      display_event      // Display pulse on blocking
);

    localparam int unsigned    RATIO_W_L = efpb_pkg::RATIO_W;
    // Settings registers; none of them are part of a setting group
    logic [31:0]               ctrl;
    logic [15:0]               residual_pickup_level;
    logic [15:0]               measured_residual_magnitude;
    logic [RATIO_W_L-1:0]      ratio;
    logic                      picked;
    logic                      blk_smp;
    logic                      start_r;
    logic                      trip_r;
    logic                      blocked_r;
    logic [2:0]                last_fault;
    logic [15:0]               angle;
    logic [31:0]               ms_count;
    logic [$clog2(CYCLE_CLKS)-1:0] cyc_cnt;
    logic [$clog2(TS_CLKS)-1:0]    ts_cnt;
    logic                      cycle_tick;
    logic                      aw_held;
    logic                      w_held;
    logic [7:0]                aw_addr;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;

    wire efpb_pkg::efpb_remote_e remote = efpb_pkg::efpb_remote_e'(ctrl[efpb_pkg::CTL_REMOTE +: 2]);
    wire efpb_pkg::efpb_status_e force_req = efpb_pkg::efpb_status_e'(ctrl[efpb_pkg::CTL_FORCE +: 2]);
    wire efpb_pkg::efpb_mag_e    mag_sel = efpb_pkg::efpb_mag_e'(ctrl[efpb_pkg::CTL_MAG +: 2]);
    wire efpb_pkg::efpb_insel_e  in_sel = efpb_pkg::efpb_insel_e'(ctrl[efpb_pkg::CTL_INSEL +: 2]);
    wire                         inrush_en = ctrl[efpb_pkg::CTL_INRUSH];
    wire                         sw_block = ctrl[efpb_pkg::CTL_SWBLK];

    // Forcing has effect only while the global switch is on
    wire forced = forcing_enable && (force_req != efpb_pkg::ST_NORMAL);

    // Magnitude select is ignored for the calculated channel
    wire efpb_pkg::efpb_chan_s chan_sel =
        (in_sel == efpb_pkg::IN_SENSITIVE) ? sensitive_residual_channel : coarse_residual_channel;
    wire [15:0] mag_pick =
        (mag_sel == efpb_pkg::MAG_TRMS) ? chan_sel.trms :
        (mag_sel == efpb_pkg::MAG_P2P)  ? chan_sel.p2p  : chan_sel.rms;
    wire [15:0] next_mag = (in_sel == efpb_pkg::IN_CALC) ? calculated_residual_channel : mag_pick;

    // Threshold scaled by 100 so the 97 percent release needs no divider
    wire [23:0] mag_x100  = measured_residual_magnitude * efpb_pkg::FULL_PCT;
    wire [23:0] set_x100  = residual_pickup_level * efpb_pkg::FULL_PCT;
    wire [23:0] set_x97   = residual_pickup_level * efpb_pkg::RESET_PCT;
    wire        over      = mag_x100 > set_x100;
    wire        under_rel = mag_x100 < set_x97;
    wire        next_picked = picked ? !under_rel : over;

    // Ratio in hundredths; saturates when level is zero or ratio huge
    wire [23:0] ratio_full = (residual_pickup_level == 16'h0000) ? 24'hFFFFFF : (mag_x100 / {8'h00, residual_pickup_level});
    wire [RATIO_W_L-1:0] next_ratio = (ratio_full > 24'h00FFFF) ? 16'hFFFF : ratio_full[15:0];

    wire blk_raw = block_in || (inrush_en && inrush_detect) || (forcing_enable && sw_block);

    wire next_start   = forced ? (force_req == efpb_pkg::ST_START)   : (next_picked && !blk_smp);
    wire next_blocked = forced ? (force_req == efpb_pkg::ST_BLOCKED) : (next_picked && blk_smp);
    // Trip rides on the same start decision, so an instant trip shares the start stamp
    wire next_trip    = forced ? (force_req == efpb_pkg::ST_TRIP)    : (next_picked && !blk_smp && trip_in);

    wire efpb_pkg::efpb_status_e cond =
        trip_r ? efpb_pkg::ST_TRIP : blocked_r ? efpb_pkg::ST_BLOCKED :
        start_r ? efpb_pkg::ST_START : efpb_pkg::ST_NORMAL;

    // Program-cycle divider and 1 ms stamp counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_cnt  <= '0;
            ts_cnt   <= '0;
            ms_count <= 32'h0000_0000;
        end else begin
            cyc_cnt  <= cycle_tick ? '0 : cyc_cnt + 1'b1;
            ts_cnt   <= (ts_cnt == ($clog2(TS_CLKS))'(TS_CLKS - 1)) ? '0 : ts_cnt + 1'b1;
            if (ts_cnt == ($clog2(TS_CLKS))'(TS_CLKS - 1)) begin
                ms_count <= ms_count + 32'h0000_0001;
            end
        end
    end
    assign cycle_tick = (cyc_cnt == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1));

    // Blocking is captured first in the cycle; evaluation uses it next tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blk_smp <= 1'b0;
        end else if (cycle_tick) begin
            blk_smp <= blk_raw;
        end
    end

    // Stage evaluation once per program cycle, a clock after the block sample
    logic eval_tick;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eval_tick <= 1'b0;
            measured_residual_magnitude <= 16'h0000;
            picked    <= 1'b0;
            ratio     <= 16'h0000;
            start_r   <= 1'b0;
            trip_r    <= 1'b0;
            blocked_r <= 1'b0;
            angle     <= 16'h0000;
        end else begin
            eval_tick <= cycle_tick;
            if (cycle_tick) begin
                measured_residual_magnitude <= next_mag;
            end
            if (eval_tick) begin
                picked    <= next_picked;
                ratio     <= next_ratio;
                start_r   <= next_start;
                trip_r    <= next_trip;
                blocked_r <= next_blocked;
                angle     <= voltages_present ? angle_vs_voltage : angle_vs_current;
            end
        end
    end

    // Events and stamp: start and trip in one evaluation share one stamp
    efpb_pkg::efpb_events_s next_events;
    assign next_events.start_on  = eval_tick && next_start && !start_r;
    assign next_events.start_off = eval_tick && !next_start && start_r;
    assign next_events.trip_on   = eval_tick && next_trip && !trip_r;
    assign next_events.trip_off  = eval_tick && !next_trip && trip_r;
    assign next_events.block_on  = eval_tick && next_blocked && !blocked_r;
    assign next_events.block_off = eval_tick && !next_blocked && blocked_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            events        <= '0;
            event_stamp   <= 32'h0000_0000;
            event_current <= 16'h0000;
            display_event <= 1'b0;
            last_fault    <= 3'h0;
        end else begin
            events        <= next_events;
            display_event <= next_events.block_on;
            if (|next_events) begin
                event_stamp   <= ms_count;
                event_current <= measured_residual_magnitude;
            end
            if (next_events.start_on || next_events.block_on) begin
                last_fault <= fault_type_in;
            end
        end
    end
    assign start_out   = start_r;
    assign trip_out    = trip_r;
    assign blocked_out = blocked_r;

    // AXI4-Lite slave: address and data taken in either order
    wire wr_go  = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctl = wr_go && (aw_addr == efpb_pkg::REG_CTRL);
    wire wr_pu  = wr_go && (aw_addr == efpb_pkg::REG_PICKUP);
    wire wr_ok  = (aw_addr == efpb_pkg::REG_CTRL) || (aw_addr == efpb_pkg::REG_PICKUP);
    wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire scada_ok = scada_write && (remote == efpb_pkg::REMOTE_ALLOWED);
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= efpb_pkg::RESP_OKAY;
            ctrl    <= efpb_pkg::CTRL_RESET;
            residual_pickup_level <= efpb_pkg::PICKUP_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? efpb_pkg::RESP_OKAY : efpb_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_ctl) begin
                ctrl <= ((ctrl & ~strb_mask) | (w_data & strb_mask)) & 32'h0000_03FF;
            end
            if (wr_pu) begin
                residual_pickup_level <= (residual_pickup_level & ~strb_mask[15:0]) | (w_data[15:0] & strb_mask[15:0]);
            end else if (scada_ok) begin
                residual_pickup_level <= scada_level;
            end
        end
    end

    // Read side
    logic [31:0] next_rdata;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            efpb_pkg::REG_CTRL:   next_rdata = ctrl;
            efpb_pkg::REG_PICKUP: next_rdata = {16'h0000, residual_pickup_level};
            efpb_pkg::REG_STATUS: next_rdata = {24'h000000, 1'b0, last_fault, blk_smp, picked, cond};
            efpb_pkg::REG_RATIO:  next_rdata = {16'h0000, ratio};
            efpb_pkg::REG_ANGLE:  next_rdata = {16'h0000, angle};
            efpb_pkg::REG_OPTIME: next_rdata = expected_time;
            efpb_pkg::REG_REMAIN: next_rdata = start_r ? remaining_time : 32'h0000_0000;
            efpb_pkg::REG_EVENT:  next_rdata = {16'h0000, event_current};
            efpb_pkg::REG_TSTAMP: next_rdata = event_stamp;
            default: begin
                next_rdata = 32'h0000_0000;
                rd_ok      = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= efpb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_ok ? efpb_pkg::RESP_OKAY : efpb_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    AST_NO_START_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
        (eval_tick && !forced && blk_smp) |=> !start_out)
        else $error("start asserted while blocked");
    AST_BLOCKED_AT_PICKUP: assert property (@(posedge aclk) disable iff (!aresetn)
        (eval_tick && !forced && next_picked && blk_smp) |=> blocked_out)
        else $error("blocked output missing");
    AST_START_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        (eval_tick && !forced && start_out && blk_smp) |=> (!start_out && events.start_off))
        else $error("start not dropped on blocking");
    AST_DISPLAY: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(blocked_out) |-> display_event)
        else $error("no display event");
    AST_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
        (eval_tick && forced && force_req == efpb_pkg::ST_TRIP) |=> (trip_out && !start_out))
        else $error("forced trip ignored");
    AST_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
        (eval_tick && picked && !under_rel) |=> picked)
        else $error("released above 97 percent");
    AST_PICKUP: assert property (@(posedge aclk) disable iff (!aresetn)
        (eval_tick && over) |=> picked)
        else $error("no pick-up above level");
    AST_REMOTE: assert property (@(posedge aclk) disable iff (!aresetn)
        (scada_write && remote != efpb_pkg::REMOTE_ALLOWED && !wr_pu) |=> $stable(residual_pickup_level))
        else $error("SCADA write not gated");
    AST_STAMP: assert property (@(posedge aclk) disable iff (!aresetn)
        (next_events.start_on && next_events.trip_on) |=> (event_stamp == $past(ms_count)))
        else $error("stamp mismatch");
    COV_START: cover property (@(posedge aclk) $rose(start_out));
    COV_BLOCK: cover property (@(posedge aclk) $rose(blocked_out));
    COV_TRIP: cover property (@(posedge aclk) $rose(trip_out));
    COV_DROP: cover property (@(posedge aclk) events.start_off && blk_smp);

endmodule

// ---- dv/efpb_partner.sv ----
/*
 * Blocking matrix stand-in: turns the bench's request into the stage's
 * blocking input. Assumes the bench asks well before any operate delay.
 */
`timescale 1ns/1ps
module efpb_partner (
    input  wire logic aclk,     // Stage clock
    input  wire logic blk_req,  // Bench request
    output logic      block_in  // Blocking matrix output
);
    initial block_in = 1'b0;
    // Registered, so the level moves just after an edge and comes a clock late
    always @(posedge aclk) begin
        block_in <= blk_req;
    end
endmodule

// ---- dv/tb_efpb_stage.sv ----
/*
 * Bench for efpb_stage: AXI4-Lite master tasks and an integer model of the
 * pick-up, release and blocking path. Assumes a shortened evaluation cycle.
 */
`timescale 1ns/1ps
module tb_efpb_stage;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, done = 1'b0, blk_req = 1'b0, scada_write = 1'b0;
    logic trip_in = 1'b0, inrush = 1'b0, forcing = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd = 32'h0;
    logic [1:0] rs = 2'h0;
    logic [15:0] scada_level = 16'h0;
    logic [95:0] misc = '0;
    efpb_pkg::efpb_chan_s coarse = '0, sens = '0;
    wire awready, wready, bvalid, arready, rvalid, block_in, start_out, blocked_out, trip_out;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int n_errors = 0, total_checks = 0, lvl = 1200, picked = 0, i, mag = 0, blk = 0;
    int mags[8] = '{150, 201, 194, 193, 201, 201, 0, 201};
    bit blks[8] = '{0, 0, 0, 0, 0, 1, 1, 1};
    always #5 aclk = ~aclk;
    efpb_partner u_partner (.aclk(aclk), .blk_req(blk_req), .block_in(block_in));
    efpb_stage #(.CYCLE_CLKS(8), .TS_CLKS(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .coarse_residual_channel(coarse), .sensitive_residual_channel(sens),
        .calculated_residual_channel(misc[15:0]), .block_in(block_in), .inrush_detect(inrush),
        .forcing_enable(forcing), .scada_write(scada_write), .scada_level(scada_level),
        .voltages_present(misc[2]), .angle_vs_voltage(misc[31:16]), .angle_vs_current(misc[47:32]),
        .fault_type_in({1'b0, misc[49:48]}), .trip_in(trip_in), .expected_time(misc[95:64]),
        .remaining_time({16'h0, misc[63:48]}), .start_out(start_out), .trip_out(trip_out),
        .blocked_out(blocked_out),
        .events(), .event_stamp(), .event_current(), .display_event());
    // Handshakes judged on pre-edge values so each channel drops only when taken
    always @(posedge aclk) begin
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (arvalid && arready) arvalid <= 1'b0;
        if (bvalid && bready) begin
            bready <= 1'b0;
            rs <= bresp;
            done <= 1'b1;
        end
        if (rvalid && rready) begin
            rready <= 1'b0;
            rd <= rdata;
            rs <= rresp;
            done <= 1'b1;
        end
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready, done} <= {a, d, 4'b1110};
        @(posedge aclk);
        while (!done) @(posedge aclk);
    endtask
    task automatic rdr(logic [7:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready, done} <= {a, 3'b110};
        @(posedge aclk);
        while (!done) @(posedge aclk);
    endtask
    task automatic evalc(string nm);
        repeat (24) @(posedge aclk);
        chk({nm, " start"}, picked && !blk, start_out);
        chk({nm, " blocked"}, picked && blk, blocked_out);
        chk({nm, " trip"}, picked && !blk && trip_in, trip_out);
        rdr(efpb_pkg::REG_STATUS);
        chk({nm, " cond"}, !picked ? 0 : (blk ? 3 : (trip_in ? 2 : 1)), rd[1:0]);
        rdr(efpb_pkg::REG_RATIO);
        chk({nm, " ratio"}, mag * 100 / lvl, rd);
        rdr(efpb_pkg::REG_REMAIN);
        chk({nm, " remain"}, (picked && !blk) ? misc[63:48] : 0, rd);
    endtask
    initial begin
        void'($urandom(32'hA2B5F678));
        misc <= {$urandom, $urandom, $urandom};
        {sens.trms, sens.p2p, coarse.trms, coarse.p2p} <= {$urandom, $urandom};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(efpb_pkg::REG_CTRL);
        chk("ctrl", efpb_pkg::CTRL_RESET, rd);
        rdr(efpb_pkg::REG_PICKUP);
        chk("pickup", {16'h0, efpb_pkg::PICKUP_RESET}, rd);
        rdr(8'hFC);
        chk("unmapped", efpb_pkg::RESP_SLVERR, rs);
        lvl = 200;
        wr(efpb_pkg::REG_PICKUP, lvl);
        {scada_write, scada_level} <= {1'b1, 16'h012C};
        @(posedge aclk) scada_write <= 1'b0;
        rdr(efpb_pkg::REG_PICKUP);
        chk("scada off", lvl, rd);
        $display("test defaults done");
        for (i = 0; i < 8; i++) begin
            @(posedge aclk);
            coarse.rms <= mags[i];
            sens.rms <= 16'h0;
            blk_req <= blks[i];
            mag = mags[i];
            blk = blks[i];
            picked = picked ? (mags[i] * 100 >= lvl * 97) : (mags[i] > lvl);
            evalc("step");
        end
        $display("test pickup done");
        wr(efpb_pkg::REG_CTRL, 32'h0000_0092);
        {scada_write, scada_level, blk_req, coarse.rms} <= {1'b1, 16'h012C, 1'b0, 16'h0};
        @(posedge aclk) scada_write <= 1'b0;
        lvl = 300;
        rdr(efpb_pkg::REG_PICKUP);
        chk("scada on", lvl, rd);
        sens.rms <= 16'h015E;
        {mag, blk, picked} = {32'd350, 32'd0, 32'd1};
        evalc("sensitive");
        rdr(efpb_pkg::REG_STATUS);
        chk("fault", misc[49:48], rd[6:4]);
        rdr(efpb_pkg::REG_ANGLE);
        chk("angle", misc[2] ? misc[31:16] : misc[47:32], rd);
        rdr(efpb_pkg::REG_OPTIME);
        chk("optime", misc[95:64], rd);
        $display("test select done");
        {sens.rms, trip_in} <= {16'h0, 1'b1};
        {mag, picked} = {32'd0, 32'd0};
        evalc("trip idle");
        sens.rms <= 16'h015E;
        {mag, picked} = {32'd350, 32'd1};
        evalc("instant");
        $display("test trip done");
        wr(efpb_pkg::REG_CTRL, 32'h0000_0192);
        inrush <= 1'b1;
        blk = 1;
        evalc("inrush");
        {inrush, forcing} <= 2'b01;
        wr(efpb_pkg::REG_CTRL, 32'h0000_0292);
        evalc("swblock");
        $display("test blocking done");
        wr(efpb_pkg::REG_CTRL, 32'h0000_009A);
        repeat (24) @(posedge aclk);
        chk("forced start", 0, start_out);
        chk("forced trip", 1, trip_out);
        rdr(efpb_pkg::REG_STATUS);
        chk("forced cond", 2, rd[1:0]);
        forcing <= 1'b0;
        blk = 0;
        evalc("unforced");
        $display("test forcing done");
        end_sim;
    end
    initial begin
        repeat (6000) @(posedge aclk);
        n_errors++;
        end_sim;
    end
endmodule
